// ---- logic/siu_pkg.sv ----
// Package of register map, field positions and reset values for the six source interrupt unit.
package siu_pkg;

  // ---------------------------------------------------------------------------
  // Bus geometry
  // ---------------------------------------------------------------------------
  localparam int          SIU_ADDR_W = 12;
  localparam int          SIU_NSRC   = 6;
  localparam int          SIU_NLINE  = 7;

  // ---------------------------------------------------------------------------
  // Register indices; the byte address is four times the index
  // ---------------------------------------------------------------------------
  localparam logic [9:0]  SIU_IDX_REQ    = 10'h0FA;
  localparam logic [9:0]  SIU_IDX_MASK   = 10'h0FB;
  localparam logic [9:0]  SIU_IDX_PRIO   = 10'h0F9;
  localparam logic [9:0]  SIU_IDX_P3MODE = 10'h0F7;
  localparam logic [9:0]  SIU_IDX_BTCTL  = 10'h0F0;
  localparam logic [9:0]  SIU_IDX_WTCTL  = 10'h0F2;
  localparam logic [9:0]  SIU_IDX_EVSTAT = 10'h0E0;
  localparam logic [9:0]  SIU_IDX_EVMASK = 10'h0E1;
  localparam logic [9:0]  SIU_IDX_CORE   = 10'h0E2;

  localparam logic [11:0] SIU_ADDR_REQ    = {SIU_IDX_REQ, 2'b00};
  localparam logic [11:0] SIU_ADDR_MASK   = {SIU_IDX_MASK, 2'b00};
  localparam logic [11:0] SIU_ADDR_PRIO   = {SIU_IDX_PRIO, 2'b00};
  localparam logic [11:0] SIU_ADDR_P3MODE = {SIU_IDX_P3MODE, 2'b00};
  localparam logic [11:0] SIU_ADDR_BTCTL  = {SIU_IDX_BTCTL, 2'b00};
  localparam logic [11:0] SIU_ADDR_WTCTL  = {SIU_IDX_WTCTL, 2'b00};
  localparam logic [11:0] SIU_ADDR_EVSTAT = {SIU_IDX_EVSTAT, 2'b00};
  localparam logic [11:0] SIU_ADDR_EVMASK = {SIU_IDX_EVMASK, 2'b00};
  localparam logic [11:0] SIU_ADDR_CORE   = {SIU_IDX_CORE, 2'b00};

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int          SIU_EDGE_HI_BIT   = 7;
  localparam int          SIU_EDGE_LO_BIT   = 6;
  localparam int          SIU_GLOBAL_EN_BIT = 7;
  localparam int          SIU_ANALOG_BIT    = 1;
  localparam int          SIU_TMR_STAT_BIT  = 5;
  localparam int          SIU_TMR_IE_BIT    = 1;
  localparam int          SIU_EV_GRANT_BIT  = 0;
  localparam int          SIU_EV_WAKE_BIT   = 1;

  // ---------------------------------------------------------------------------
  // Reset values and bus answers
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  SIU_RST_BYTE  = 8'h00;
  localparam logic [1:0]  SIU_RESP_OKAY = 2'h0;
  localparam logic [1:0]  SIU_RESP_SLV  = 2'h2;
  localparam logic [1:0]  SIU_ARM_COUNT = 2'h3;

endpackage : siu_pkg

// ---- logic/siu_edge_if.sv ----
// Interface between the unit and its synchronising edge detector.
`timescale 1ns/1ps
`default_nettype none
interface siu_edge_if #(parameter int N = 7);
  logic [N-1:0] raw;
  logic [N-1:0] rise_en;
  logic [N-1:0] fall_en;
  logic [N-1:0] pulse;

  modport det  (input raw, input rise_en, input fall_en, output pulse);
  modport user (output raw, output rise_en, output fall_en, input pulse);
endinterface : siu_edge_if
`default_nettype wire

// ---- logic/siu_edge_detect.sv ----
// Two-stage synchroniser and selectable edge detector for asynchronous request lines.
`timescale 1ns/1ps
`default_nettype none
module siu_edge_detect
  import siu_pkg::*;
#(
  parameter int N = SIU_NLINE
)
(
  input  wire logic clk,
  input  wire logic rst_n,
  siu_edge_if.det   eif
);

  logic [N-1:0] meta_q;
  logic [N-1:0] sync_q;
  logic [N-1:0] prev_q;
  logic [1:0]   arm_q;
  logic         armed;

  // ---------------------------------------------------------------------------
  // Synchroniser and history
  // ---------------------------------------------------------------------------
  // The first stage feeds only the second stage.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
      arm_q  <= '0;
    end
    else
    begin
      meta_q <= eif.raw;
      sync_q <= meta_q;
      prev_q <= sync_q;
      if (!armed)
        arm_q <= arm_q + 2'h1;
    end
  end

  // Edges are only trusted once the history holds real pin samples.
  assign armed     = (arm_q == SIU_ARM_COUNT);
  assign eif.pulse = {N{armed}} & ((sync_q & ~prev_q & eif.rise_en) |
                                   (~sync_q & prev_q & eif.fall_en));

endmodule : siu_edge_detect
`default_nettype wire

// ---- logic/siu_interrupt_unit.sv ----
// Six source interrupt unit with AXI4-Lite register access and core request port.
//
// Summary of operation
// - Six maskable requests: three port-3 lines, two timers, one low-voltage detector.
// - Mask register enables each request alone and all of them globally.
// - Port-3 mode bit 1 picks line three or stop-recovery logic for request 1.
// - Request n owns vector bytes 2n and 2n+1 in program memory.
// - Requests 3,4,5 are word timer, byte timer, detector; request 1 falling only.
// - A priority register steers the encoder choosing among several pending requests.
// - A grant starts the machine cycle and disables all further interrupts.
// - Pending bits keep recording while masked so software can poll them.
// - Comparator one feeds request 2, comparator two feeds request 0.
// - Request register bits 7 and 6 choose the edges of requests 2 and 0.
// - In halt the core clock stops while timers and all sources stay active.
// - Halt ends only when an enabled request is offered; return follows halt.
// - Timer time-out sets status bit 5; request only if control bit 1 set.
`timescale 1ns/1ps
`default_nettype none
module siu_interrupt_unit
  import siu_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // AXI4-Lite slave.
  input  wire logic [SIU_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [SIU_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // Asynchronous request sources.
  input  wire logic                  port3_line_one,
  input  wire logic                  port3_line_two,
  input  wire logic                  port3_line_three,
  input  wire logic                  comparator_input_one,
  input  wire logic                  comparator_input_two,
  input  wire logic                  stop_recovery_src,
  input  wire logic                  low_voltage_detector,
  // Timer time-out pulses from the same clock.
  input  wire logic                  byte_timer_timeout,
  input  wire logic                  word_timer_timeout,
  // Core side.
  output logic                       irq_req,
  output logic [7:0]                 irq_vector,
  input  wire logic                  irq_ack,
  input  wire logic                  halt_enter,
  output logic                       core_clk_en,
  output logic                       intr_out
);

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  logic                  aw_hold_q;
  logic [SIU_ADDR_W-1:0] awaddr_q;
  logic                  w_hold_q;
  logic [7:0]            wbyte_q;
  logic                  wlane_q;
  logic                  bvalid_q;
  logic [1:0]            bresp_q;
  logic                  rvalid_q;
  logic [31:0]           rdata_q;
  logic [1:0]            rresp_q;

  logic [1:0]            edge_sel_q;
  logic [5:0]            pend_q;
  logic [5:0]            pend_d;
  logic [5:0]            mask_q;
  logic                  gen_q;
  logic [2:0]            prio_q;
  logic                  analog_q;
  logic                  bt_stat_q;
  logic                  bt_ie_q;
  logic                  wt_stat_q;
  logic                  wt_ie_q;
  logic [1:0]            ev_stat_q;
  logic [1:0]            ev_stat_d;
  logic [1:0]            ev_mask_q;
  logic                  halted_q;
  logic                  req_q;
  logic [2:0]            win_q;

  logic                  wr_fire;
  logic                  wr_en;
  logic                  wr_hit;
  logic                  rd_fire;
  logic                  rd_hit;
  logic [7:0]            rd_byte;
  logic [7:0]            wb;
  logic                  wr_req;
  logic                  wr_mask;
  logic                  wr_prio;
  logic                  wr_p3m;
  logic                  wr_bt;
  logic                  wr_wt;
  logic                  wr_evs;
  logic                  wr_evm;
  logic [5:0]            src_set;
  logic [5:0]            sw_clr;
  logic [5:0]            ack_clr;
  logic [5:0]            active;
  logic                  grant;
  logic                  wake;

  siu_edge_if #(.N(SIU_NLINE)) eif ();

  // ---------------------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------------------
  // Rotating priority: the search starts at the programmed top request.
  function automatic logic [2:0] siu_pick(input logic [5:0] act, input logic [2:0] top);
    logic [2:0] win;
    logic       found;
    int         start;
    int         k;
    win   = 3'h0;
    found = 1'b0;
    start = (int'(top) < SIU_NSRC) ? int'(top) : 0;
    for (int i = 0; i < SIU_NSRC; i++)
    begin
      k = (start + i) % SIU_NSRC;
      if (!found && act[k])
      begin
        win   = k[2:0];
        found = 1'b1;
      end
    end
    return win;
  endfunction : siu_pick

  // One-hot mask of a request index.
  function automatic logic [5:0] siu_onehot(input logic [2:0] idx);
    return 6'(6'h01 << idx);
  endfunction : siu_onehot

  // Mapped register offsets; any other address answers with an error code.
  function automatic logic siu_mapped(input logic [SIU_ADDR_W-1:0] a);
    return (a == SIU_ADDR_REQ) | (a == SIU_ADDR_MASK) | (a == SIU_ADDR_PRIO) |
           (a == SIU_ADDR_P3MODE) | (a == SIU_ADDR_BTCTL) | (a == SIU_ADDR_WTCTL) |
           (a == SIU_ADDR_EVSTAT) | (a == SIU_ADDR_EVMASK) | (a == SIU_ADDR_CORE);
  endfunction : siu_mapped

  // ---------------------------------------------------------------------------
  // AXI4-Lite handshakes
  // ---------------------------------------------------------------------------
  // Address and data are taken in either order; the write is done once both are held.
  assign s_axi_awready = ~aw_hold_q & ~bvalid_q;
  assign s_axi_wready  = ~w_hold_q & ~bvalid_q;
  assign wr_fire       = aw_hold_q & w_hold_q & ~bvalid_q;
  assign wr_en         = wr_fire & wlane_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = ~rvalid_q;
  assign rd_fire       = s_axi_arvalid & ~rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  // Write channel state.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_hold_q <= 1'b0;
      awaddr_q  <= '0;
      w_hold_q  <= 1'b0;
      wbyte_q   <= SIU_RST_BYTE;
      wlane_q   <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= SIU_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_q <= 1'b1;
        wbyte_q  <= s_axi_wdata[7:0];
        wlane_q  <= s_axi_wstrb[0];
      end
      if (wr_fire)
      begin
        aw_hold_q <= 1'b0;
        w_hold_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_hit ? SIU_RESP_OKAY : SIU_RESP_SLV;
      end
      else if (bvalid_q && s_axi_bready)
        bvalid_q <= 1'b0;
    end
  end

  // Read channel state.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= SIU_RESP_OKAY;
    end
    else if (rd_fire)
    begin
      rvalid_q <= 1'b1;
      rdata_q  <= {24'h000000, rd_byte};
      rresp_q  <= rd_hit ? SIU_RESP_OKAY : SIU_RESP_SLV;
    end
    else if (rvalid_q && s_axi_rready)
      rvalid_q <= 1'b0;
  end

  // ---------------------------------------------------------------------------
  // Register decode
  // ---------------------------------------------------------------------------
  // Write strobes per register; only byte lane 0 carries register bits.
  assign wb      = wbyte_q;
  assign wr_req  = wr_en & (awaddr_q == SIU_ADDR_REQ);
  assign wr_mask = wr_en & (awaddr_q == SIU_ADDR_MASK);
  assign wr_prio = wr_en & (awaddr_q == SIU_ADDR_PRIO);
  assign wr_p3m  = wr_en & (awaddr_q == SIU_ADDR_P3MODE);
  assign wr_bt   = wr_en & (awaddr_q == SIU_ADDR_BTCTL);
  assign wr_wt   = wr_en & (awaddr_q == SIU_ADDR_WTCTL);
  assign wr_evs  = wr_en & (awaddr_q == SIU_ADDR_EVSTAT);
  assign wr_evm  = wr_en & (awaddr_q == SIU_ADDR_EVMASK);
  assign wr_hit  = siu_mapped(awaddr_q);

  // Read multiplexer; unmapped addresses read zero with an error answer.
  assign rd_hit  = siu_mapped(s_axi_araddr);
  assign rd_byte =
    (s_axi_araddr == SIU_ADDR_REQ)    ? {edge_sel_q, pend_q} :
    (s_axi_araddr == SIU_ADDR_MASK)   ? {gen_q, 1'b0, mask_q} :
    (s_axi_araddr == SIU_ADDR_PRIO)   ? {5'h00, prio_q} :
    (s_axi_araddr == SIU_ADDR_P3MODE) ? {6'h00, analog_q, 1'b0} :
    (s_axi_araddr == SIU_ADDR_BTCTL)  ? {2'h0, bt_stat_q, 3'h0, bt_ie_q, 1'b0} :
    (s_axi_araddr == SIU_ADDR_WTCTL)  ? {2'h0, wt_stat_q, 3'h0, wt_ie_q, 1'b0} :
    (s_axi_araddr == SIU_ADDR_EVSTAT) ? {6'h00, ev_stat_q} :
    (s_axi_araddr == SIU_ADDR_EVMASK) ? {6'h00, ev_mask_q} :
    (s_axi_araddr == SIU_ADDR_CORE)   ? {7'h00, halted_q} : 8'h00;

  // ---------------------------------------------------------------------------
  // Source conditioning
  // ---------------------------------------------------------------------------
  // Line order: line one, line two, line three, comparator one, comparator two,
  // stop-recovery logic, low-voltage detector.
  assign eif.raw = {low_voltage_detector, stop_recovery_src, comparator_input_two,
                    comparator_input_one, port3_line_three, port3_line_two,
                    port3_line_one};
  // Request 2 edges from bit 7, request 0 edges from bit 6; both set gives both edges.
  assign eif.rise_en = {1'b1, 1'b0, edge_sel_q[0], edge_sel_q[1], 1'b0,
                        edge_sel_q[0], edge_sel_q[1]};
  assign eif.fall_en = {1'b0, 1'b1, ~edge_sel_q[0] | edge_sel_q[1],
                        ~edge_sel_q[1] | edge_sel_q[0], 1'b1,
                        ~edge_sel_q[0] | edge_sel_q[1], ~edge_sel_q[1] | edge_sel_q[0]};

  siu_edge_detect #(
    .N     (SIU_NLINE)
  ) u_edge (
    .clk   (clk),
    .rst_n (rst_n),
    .eif   (eif)
  );

  // Request sets; analog setting swaps pins for comparators and recovery logic.
  assign src_set[0] = analog_q ? eif.pulse[4] : eif.pulse[1];
  assign src_set[1] = analog_q ? eif.pulse[5] : eif.pulse[2];
  assign src_set[2] = analog_q ? eif.pulse[3] : eif.pulse[0];
  assign src_set[3] = word_timer_timeout & wt_ie_q;
  assign src_set[4] = byte_timer_timeout & bt_ie_q;
  assign src_set[5] = eif.pulse[6];

  // ---------------------------------------------------------------------------
  // Pending requests and arbitration
  // ---------------------------------------------------------------------------
  // A one written to a pending bit clears it; a grant clears the winner.
  assign sw_clr  = wr_req ? wb[5:0] : 6'h00;
  assign ack_clr = grant ? siu_onehot(win_q) : 6'h00;
  assign pend_d  = src_set | (pend_q & ~sw_clr & ~ack_clr);
  assign active  = pend_q & mask_q & {SIU_NSRC{gen_q}};
  assign grant   = req_q & irq_ack;
  assign wake    = halted_q & req_q;

  // Outputs to the core come straight from flip-flops, except intr_out, which gates status with mask.
  assign irq_req     = req_q;
  assign irq_vector  = {4'h0, win_q, 1'b0};
  assign core_clk_en = ~halted_q;
  assign intr_out    = |(ev_stat_q & ev_mask_q);

  // Pending register and edge selection.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pend_q     <= '0;
      edge_sel_q <= '0;
    end
    else
    begin
      pend_q <= pend_d;
      if (wr_req)
        edge_sel_q <= {wb[SIU_EDGE_HI_BIT], wb[SIU_EDGE_LO_BIT]};
    end
  end

  // Request offer to the core; withdrawn after each grant until the global enable is set again.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      req_q <= 1'b0;
      win_q <= '0;
    end
    else
    begin
      req_q <= |active & ~grant;
      win_q <= siu_pick(active, prio_q);
    end
  end

  // Mask, global enable, priority and port mode.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mask_q   <= '0;
      gen_q    <= 1'b0;
      prio_q   <= '0;
      analog_q <= 1'b0;
    end
    else
    begin
      if (wr_mask)
        mask_q <= wb[5:0];
      if (grant)
        gen_q <= 1'b0;
      else if (wr_mask)
        gen_q <= wb[SIU_GLOBAL_EN_BIT];
      if (wr_prio)
        prio_q <= wb[2:0];
      if (wr_p3m)
        analog_q <= wb[SIU_ANALOG_BIT];
    end
  end

  // Timer status bits: a time-out wins over a clearing write in the same cycle.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bt_stat_q <= 1'b0;
      bt_ie_q   <= 1'b0;
      wt_stat_q <= 1'b0;
      wt_ie_q   <= 1'b0;
    end
    else
    begin
      bt_stat_q <= byte_timer_timeout | (bt_stat_q & ~(wr_bt & wb[SIU_TMR_STAT_BIT]));
      wt_stat_q <= word_timer_timeout | (wt_stat_q & ~(wr_wt & wb[SIU_TMR_STAT_BIT]));
      if (wr_bt)
        bt_ie_q <= wb[SIU_TMR_IE_BIT];
      if (wr_wt)
        wt_ie_q <= wb[SIU_TMR_IE_BIT];
    end
  end

  // ---------------------------------------------------------------------------
  // Halt control and event interrupt
  // ---------------------------------------------------------------------------
  // Sources keep running in halt; only an offered enabled request restarts the core.
  assign ev_stat_d = ({wake, grant} | ev_stat_q) & ~(wr_evs ? wb[1:0] & ~{wake, grant} : 2'h0);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      halted_q  <= 1'b0;
      ev_stat_q <= '0;
      ev_mask_q <= '0;
    end
    else
    begin
      if (wake)
        halted_q <= 1'b0;
      else if (halt_enter)
        halted_q <= 1'b1;
      ev_stat_q <= ev_stat_d;
      if (wr_evm)
        ev_mask_q <= wb[1:0];
    end
  end

endmodule : siu_interrupt_unit
`default_nettype wire

// ---- dv/siu_sva.sv ----
// Checker of core handshake, halt and register read timing.
`timescale 1ns/1ps
`default_nettype none
module siu_sva (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        irq_req,
  input wire logic [7:0]  irq_vector,
  input wire logic        irq_ack,
  input wire logic        halt_enter,
  input wire logic        core_clk_en
);
  // All properties sample on clk and rest during reset.
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_ACK_DROP: assert property (irq_req && irq_ack |=> !irq_req)
    else $error("request still offered after ack");
  AST_VEC_PAIR: assert property (irq_req |-> !irq_vector[0] && irq_vector <= 8'h0A)
    else $error("vector outside the six pairs");
  AST_HALT_STOP: assert property (halt_enter && !irq_req |=> !core_clk_en)
    else $error("core clock runs after halt");
  AST_WAKE: assert property (!core_clk_en && irq_req |=> core_clk_en)
    else $error("no wake on request");
  AST_STAY: assert property (!core_clk_en && !irq_req |=> !core_clk_en)
    else $error("wake without request");
  AST_RD_ANS: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_RD_ONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  AST_RD_BYTE: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data above bit 7");
endmodule : siu_sva
bind siu_interrupt_unit siu_sva i_siu_sva (.*);
`default_nettype wire

// ---- dv/siu_core_model.sv ----
// Behavioural core that takes vectored requests from the unit.
`timescale 1ns/1ps
`default_nettype none
module siu_core_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       irq_req,
  input  wire logic [7:0] irq_vector,
  input  wire logic       core_clk_en,
  output logic            irq_ack,
  output logic [7:0]      fetch_q
);
  // Acks only while its clock runs and keeps the vector used for the fetch.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_ack <= 1'b0;
      fetch_q <= 8'h00;
    end
    else
    begin
      irq_ack <= irq_req && core_clk_en && !irq_ack;
      if (irq_ack && irq_req)
        fetch_q <= irq_vector;
    end
  end
endmodule : siu_core_model
`default_nettype wire

// ---- dv/test_six_source_interrupt_unit.sv ----
// Testbench of the six source interrupt unit.
`timescale 1ns/1ps
`default_nettype none
module test_six_source_interrupt_unit
  import siu_pkg::*;
;
  logic        clk = 0, rst_n = 0, s_axi_bready = 1, s_axi_rready = 1;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  s_axi_bresp, s_axi_rresp, lr, lb;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        port3_line_one = 0, port3_line_two = 0, port3_line_three = 1;
  logic        comparator_input_one = 0, comparator_input_two = 0, stop_recovery_src = 1;
  logic        low_voltage_detector = 0, byte_timer_timeout = 0, word_timer_timeout = 0;
  logic        irq_req, irq_ack, halt_enter = 0, core_clk_en, intr_out;
  logic [7:0]  irq_vector, fetch_q;
  int          bad_count = 0, checks = 0;
  siu_interrupt_unit i_siu_interrupt_unit (.*);
  siu_core_model i_siu_core_model (.*);
  initial forever #12.5 clk = ~clk;
  // Compares one value and counts it.
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // One register write; each channel is released after the edge that takes it.
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic ad = 0;
    logic wd = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    while (!(ad && wd))
    begin
      @(negedge clk);
      ad = ad || s_axi_awready;
      wd = wd || s_axi_wready;
      @(posedge clk);
      if (ad)
        s_axi_awvalid <= 0;
      if (wd)
        s_axi_wvalid <= 0;
    end
    do @(negedge clk); while (!s_axi_bvalid);
    lb = s_axi_bresp;
    @(posedge clk);
  endtask : wr
  // One register read compared with the expected byte.
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do @(negedge clk); while (!s_axi_arready);
    @(posedge clk);
    s_axi_arvalid <= 0;
    do @(negedge clk); while (!s_axi_rvalid);
    lr = s_axi_rresp;
    chk(s_axi_rdata, {24'h0, e});
    @(posedge clk);
  endtask : rd
  // Prints the counts and the verdict, then ends the run.
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : final_report
  // Cuts a hang short well past the expected run length.
  initial
  begin
    repeat (5000) @(posedge clk);
    bad_count++;
    final_report;
  end
  // Main sequence.
  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    rd(SIU_ADDR_MASK, 8'h00);
    chk({30'h0, lr}, {30'h0, SIU_RESP_OKAY});
    rd(12'hFFC, 8'h00);
    chk({30'h0, lr}, {30'h0, SIU_RESP_SLV});
    wr(12'hFFC, 8'h00);
    chk({30'h0, lb}, {30'h0, SIU_RESP_SLV});
    wr(SIU_ADDR_WTCTL, 8'h02);
    chk({30'h0, lb}, {30'h0, SIU_RESP_OKAY});
    byte_timer_timeout <= 1;
    word_timer_timeout <= 1;
    @(posedge clk);
    byte_timer_timeout <= 0;
    word_timer_timeout <= 0;
    rd(SIU_ADDR_BTCTL, 8'h20);
    wr(SIU_ADDR_BTCTL, 8'h22);
    byte_timer_timeout <= 1;
    @(posedge clk);
    byte_timer_timeout <= 0;
    rd(SIU_ADDR_REQ, 8'h18);
    $display("timer test done");
    wr(SIU_ADDR_PRIO, 8'h04);
    s_axi_wstrb <= 4'h0;
    wr(SIU_ADDR_PRIO, 8'h01);
    s_axi_wstrb <= 4'hF;
    rd(SIU_ADDR_PRIO, 8'h04);
    wr(SIU_ADDR_MASK, 8'h98);
    repeat (6) @(posedge clk);
    chk({24'h0, fetch_q}, 32'h8);
    rd(SIU_ADDR_MASK, 8'h18);
    rd(SIU_ADDR_REQ, 8'h08);
    chk({31'h0, intr_out}, 32'h0);
    wr(SIU_ADDR_EVMASK, 8'h01);
    chk({31'h0, intr_out}, 32'h1);
    wr(SIU_ADDR_EVSTAT, 8'h01);
    chk({31'h0, intr_out}, 32'h0);
    wr(SIU_ADDR_MASK, 8'h98);
    repeat (6) @(posedge clk);
    chk({24'h0, fetch_q}, 32'h6);
    $display("grant test done");
    for (int p = 0; p < 8; p++)
    begin
      wr(SIU_ADDR_REQ, {p[2:1], 6'h3F});
      port3_line_one <= !p[0];
      port3_line_two <= !p[0];
      repeat (6) @(posedge clk);
      rd(SIU_ADDR_REQ, {p[2:1], 3'h0, p[0] ? p[2:1] != 2 : p[2], 1'b0,
                        p[0] ? p[2:1] != 1 : p[1]});
    end
    wr(SIU_ADDR_P3MODE, 8'h02);
    comparator_input_one <= 1;
    comparator_input_two <= 1;
    stop_recovery_src <= 0;
    low_voltage_detector <= 1;
    repeat (6) @(posedge clk);
    rd(SIU_ADDR_REQ, 8'hE7);
    $display("edge test done");
    wr(SIU_ADDR_EVSTAT, 8'h03);
    halt_enter <= 1;
    @(posedge clk);
    halt_enter <= 0;
    repeat (3) @(posedge clk);
    chk({31'h0, core_clk_en}, 32'h0);
    rd(SIU_ADDR_CORE, 8'h01);
    wr(SIU_ADDR_MASK, 8'hA0);
    repeat (6) @(posedge clk);
    chk({24'h0, fetch_q}, 32'hA);
    rd(SIU_ADDR_EVSTAT, 8'h03);
    $display("halt test done");
    final_report;
  end
endmodule : test_six_source_interrupt_unit
`default_nettype wire
